//--- otpsec_pkg.sv
`default_nettype none
package otpsec_pkg;
  // OTP geometry
  localparam int OTP_SECTORS = 4;
  localparam int OTP_ROWS_PER_SECTOR = 512;
  localparam int OTP_DATA_W = 32;
  localparam int OTP_ROWS = OTP_SECTORS * OTP_ROWS_PER_SECTOR;
  localparam int OTP_ROW_W = 11;
  localparam int OTP_SPARE_ROWS = 4;
  localparam int OTP_AW = 12;
  localparam int OTP_DEPTH = OTP_ROWS + OTP_SPARE_ROWS + 1;
  localparam int OTP_SECTOR_LSB = 9;
  localparam logic [11:0] OTP_SPARE_BASE = 12'h800;
  localparam logic [11:0] OTP_SEC_ROW = 12'h804;
  localparam logic [31:0] OTP_BLANK = 32'h0000_0000;
  localparam int SRAM_AW = 14;
  // Security word fields
  localparam int SEC_JTAG_OFF = 0;
  localparam int SEC_LINK_OFF = 1;
  localparam int SEC_SECURE_BOOT = 5;
  localparam int SEC_REDUNDANT = 7;
  localparam int SEC_LOCK_LSB = 8;
  localparam int SEC_MASTER_LOCK = 12;
  localparam int SEC_JTAG_OTP_OFF = 13;
  localparam int SEC_DEBUG_OFF = 14;
  localparam int SEC_GP_LSB = 15;
  localparam int SEC_GP_MSB = 21;
  localparam int SEC_UID_LSB = 22;
  localparam int SEC_UID_MSB = 31;
  localparam int SEC_UID_W = SEC_UID_MSB - SEC_UID_LSB + 1;
  // Register offsets
  localparam logic [7:0] REG_SEC = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam logic [7:0] REG_REPAIR = 8'h18;
  // Control, status and repair fields
  localparam int CTRL_PROGRAM = 0;
  localparam int CTRL_READ = 1;
  localparam int CTRL_SEC_TARGET = 2;
  localparam int STAT_LOADED = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_REFUSED = 2;
  localparam int STAT_RUNNING = 3;
  localparam int REP_ROW_MSB = 10;
  localparam int REP_SPARE_LSB = 12;
  localparam int REP_SPARE_MSB = 13;
  localparam int REP_VALID = 15;
  localparam logic [31:0] REG_ZERO = 32'h0000_0000;
endpackage : otpsec_pkg
`default_nettype wire

//--- otpsec_mem.sv
`timescale 1ns/1ns
`default_nettype none
module otpsec_mem #(
  parameter int W = otpsec_pkg::OTP_DATA_W,
  parameter int DEPTH = otpsec_pkg::OTP_DEPTH,
  parameter int AW = otpsec_pkg::OTP_AW
) (
  input wire logic i_clk, // Tile clock
  input wire logic i_en, // Access enable
  input wire logic i_we, // Write (burn) enable
  input wire logic [AW-1:0] i_addr, // Physical row
  input wire logic [W-1:0] i_wdata, // Row write data
  output logic [W-1:0] o_rdata // Registered read data
);
  logic [W-1:0] mem [DEPTH];

  // Blank fuses read as zero
  initial
  begin
    for (int k = 0; k < DEPTH; k++)
      mem[k] = otpsec_pkg::OTP_BLANK;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_en && i_we)
      mem[i_addr] <= i_wdata;
    if (i_en)
      o_rdata <= mem[i_addr];
  end
endmodule : otpsec_mem
`default_nettype wire

//--- otpsec_lock.sv
`timescale 1ns/1ns
`default_nettype none
module otpsec_lock (
  input wire logic [31:0] i_sec, // Loaded security word
  input wire logic [otpsec_pkg::OTP_ROW_W-1:0] i_row, // Logical target row
  input wire logic i_sec_target, // Target is the security row
  output logic o_permit // Burn allowed
);
  logic [otpsec_pkg::OTP_SECTORS-1:0] lock;
  logic [1:0] sector;

  assign lock = i_sec[otpsec_pkg::SEC_LOCK_LSB +: otpsec_pkg::OTP_SECTORS];
  assign sector = i_row[otpsec_pkg::OTP_SECTOR_LSB +: 2];
  // Master lock covers the security row too; sector locks do not
  assign o_permit = !i_sec[otpsec_pkg::SEC_MASTER_LOCK] && (i_sec_target || !lock[sector]);
endmodule : otpsec_lock
`default_nettype wire

//--- otpsec_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module otpsec_ctrl #(
  parameter int COPY_ROWS = otpsec_pkg::OTP_ROWS
) (
  input wire logic i_clk, // Tile clock
  input wire logic i_rst_n, // Power-up reset, async
  input wire logic [7:0] i_addr, // Register byte address
  input wire logic [31:0] i_wdata, // Register write data
  input wire logic i_we, // Register write strobe
  input wire logic i_re, // Register read strobe
  output logic [31:0] o_rdata, // Read data, cycle after i_re
  input wire logic [1:0] i_boot_sel, // Normal boot source select
  output logic o_boot_from_otp, // Boot ROM bypassed
  output logic [1:0] o_boot_sel, // Boot source to ROM
  output logic o_core_run, // Processor released
  output logic o_sram_we, // SRAM copy write
  output logic [otpsec_pkg::SRAM_AW-1:0] o_sram_addr, // SRAM word address
  output logic [31:0] o_sram_wdata, // SRAM copy data
  input wire logic i_jtag_req, // JTAG tile-state access
  output logic o_jtag_grant, // JTAG access allowed
  input wire logic i_link_req, // Switch access from other tile
  output logic o_link_grant, // Switch access allowed
  output logic o_link_refuse, // Switch access refused
  input wire logic i_jtag_otp_rd, // JTAG OTP read request
  input wire logic i_jtag_otp_wr, // JTAG OTP program request
  input wire logic i_jtag_otp_sec, // JTAG targets security row
  input wire logic [15:0] i_jtag_otp_addr, // JTAG OTP row
  input wire logic [31:0] i_jtag_otp_wdata, // JTAG OTP data
  output logic o_jtag_otp_ack, // JTAG OTP done pulse
  output logic o_jtag_otp_refuse, // JTAG OTP refused pulse
  output logic [31:0] o_jtag_otp_rdata, // JTAG OTP read data
  input wire logic i_core_break, // Processor hit breakpoint
  input wire logic i_debug_n_in, // Debug pin level
  output logic o_debug_n_out, // Debug pin drive value
  output logic o_debug_n_oe, // Debug pin drive enable
  output logic o_debug_req, // Debug entry to processor
  output logic [otpsec_pkg::SEC_UID_W-1:0] o_jtag_user_code_extension // User code field
);
  typedef enum logic [7:0] {
    S_LOAD = 8'h01,
    S_LOADW = 8'h02,
    S_COPY = 8'h04,
    S_FLUSH = 8'h08,
    S_IDLE = 8'h10,
    S_OP = 8'h20,
    S_RDW = 8'h40,
    S_PGW = 8'h80
  } otpsec_state_t;

  localparam logic [11:0] COPY_LAST = 12'(COPY_ROWS - 1);
  localparam int RW = otpsec_pkg::OTP_ROW_W;

  otpsec_state_t state_reg, state_next;
  logic [31:0] sec_reg, sec_next;
  logic loaded_reg, loaded_next;
  logic secure_reg, secure_next;
  logic run_reg, run_next;
  logic [11:0] idx_reg, idx_next;
  logic [11:0] cpa_reg, cpa_next;
  logic cpv_reg, cpv_next;
  logic [RW-1:0] op_row_reg, op_row_next;
  logic [31:0] op_data_reg, op_data_next;
  logic op_sec_reg, op_sec_next;
  logic op_jtag_reg, op_jtag_next;
  logic op_pgm_reg, op_pgm_next;
  logic pend_pgm_reg, pend_pgm_next;
  logic pend_rd_reg, pend_rd_next;
  logic tgt_sec_reg, tgt_sec_next;
  logic refused_reg, refused_next;
  logic [15:0] addr_reg, addr_next;
  logic [31:0] data_reg, data_next;
  logic [15:0] rep_reg, rep_next;
  logic [31:0] swrd_reg, swrd_next;
  logic jack_reg, jack_next;
  logic jref_reg, jref_next;
  logic [31:0] jrd_reg, jrd_next;
  logic mem_en, mem_we;
  logic [11:0] mem_addr;
  logic [31:0] mem_wdata, mem_rdata;
  logic permit;
  logic ctrl_wr;

  // Spare row substitution applies only with redundancy enabled
  function automatic logic [11:0] otpsec_phys(input logic [RW-1:0] row, input logic [31:0] sec,
                                              input logic [15:0] rep);
    logic [11:0] p;
    p = {1'b0, row};
    if (sec[otpsec_pkg::SEC_REDUNDANT] && rep[otpsec_pkg::REP_VALID]
        && rep[otpsec_pkg::REP_ROW_MSB:0] == row)
      p = otpsec_pkg::OTP_SPARE_BASE
          + {10'h000, rep[otpsec_pkg::REP_SPARE_MSB:otpsec_pkg::REP_SPARE_LSB]};
    return p;
  endfunction : otpsec_phys

  // One array per tile instance
  otpsec_mem u_mem (
    .i_clk(i_clk),
    .i_en(mem_en),
    .i_we(mem_we),
    .i_addr(mem_addr),
    .i_wdata(mem_wdata),
    .o_rdata(mem_rdata)
  );

  otpsec_lock u_lock (
    .i_sec(sec_reg),
    .i_row(op_row_reg),
    .i_sec_target(op_sec_reg),
    .o_permit(permit)
  );

  assign ctrl_wr = i_we && i_addr == otpsec_pkg::REG_CTRL;

  always_comb
  begin
    state_next = state_reg;
    sec_next = sec_reg;
    loaded_next = loaded_reg;
    secure_next = secure_reg;
    run_next = run_reg || state_reg == S_IDLE;
    idx_next = idx_reg;
    cpa_next = idx_reg;
    cpv_next = 1'b0;
    op_row_next = op_row_reg;
    op_data_next = op_data_reg;
    op_sec_next = op_sec_reg;
    op_jtag_next = op_jtag_reg;
    op_pgm_next = op_pgm_reg;
    pend_pgm_next = pend_pgm_reg;
    pend_rd_next = pend_rd_reg;
    tgt_sec_next = tgt_sec_reg;
    refused_next = refused_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    rep_next = rep_reg;
    swrd_next = swrd_reg;
    jack_next = 1'b0;
    jref_next = 1'b0;
    jrd_next = jrd_reg;
    mem_en = 1'b0;
    mem_we = 1'b0;
    mem_addr = otpsec_pkg::OTP_SEC_ROW;
    mem_wdata = op_data_reg;
    if (i_we && i_addr == otpsec_pkg::REG_STATUS && i_wdata[otpsec_pkg::STAT_REFUSED])
      refused_next = 1'b0;
    if (i_we && i_addr == otpsec_pkg::REG_ADDR)
      addr_next = i_wdata[15:0];
    if (i_we && i_addr == otpsec_pkg::REG_DATA)
      data_next = i_wdata;
    if (i_we && i_addr == otpsec_pkg::REG_REPAIR)
      rep_next = i_wdata[15:0];
    if (ctrl_wr)
      tgt_sec_next = i_wdata[otpsec_pkg::CTRL_SEC_TARGET];
    unique case (state_reg)
      S_LOAD:
      begin
        mem_en = 1'b1;
        state_next = S_LOADW;
      end
      S_LOADW:
      begin
        sec_next = mem_rdata;
        loaded_next = 1'b1;
        secure_next = mem_rdata[otpsec_pkg::SEC_SECURE_BOOT];
        idx_next = 12'h000;
        state_next = mem_rdata[otpsec_pkg::SEC_SECURE_BOOT] ? S_COPY : S_IDLE;
      end
      S_COPY:
      begin
        // Image fetched from row 0 upward
        mem_en = 1'b1;
        mem_addr = otpsec_phys(idx_reg[RW-1:0], sec_reg, rep_reg);
        cpv_next = 1'b1;
        idx_next = idx_reg + 12'h001;
        if (idx_reg == COPY_LAST)
          state_next = S_FLUSH;
      end
      S_FLUSH:
        state_next = S_IDLE;
      S_IDLE:
      begin
        // Software first; JTAG waits while a pulse is still out
        if (pend_pgm_reg || pend_rd_reg)
        begin
          op_row_next = addr_reg[RW-1:0];
          op_data_next = data_reg;
          op_sec_next = tgt_sec_reg;
          op_jtag_next = 1'b0;
          op_pgm_next = pend_pgm_reg;
          if (pend_pgm_reg)
            pend_pgm_next = 1'b0;
          else
            pend_rd_next = 1'b0;
          state_next = S_OP;
        end
        else if ((i_jtag_otp_rd || i_jtag_otp_wr) && !jack_reg && !jref_reg)
        begin
          if (sec_reg[otpsec_pkg::SEC_JTAG_OTP_OFF])
            jref_next = 1'b1;
          else
          begin
            op_row_next = i_jtag_otp_addr[RW-1:0];
            op_data_next = i_jtag_otp_wdata;
            op_sec_next = i_jtag_otp_sec;
            op_jtag_next = 1'b1;
            op_pgm_next = i_jtag_otp_wr;
            state_next = S_OP;
          end
        end
      end
      S_OP:
      begin
        mem_addr = op_sec_reg ? otpsec_pkg::OTP_SEC_ROW : otpsec_phys(op_row_reg, sec_reg, rep_reg);
        if (op_pgm_reg && !permit)
        begin
          // Nothing reaches the array on a locked burn
          // Set wins over a clear written in the same cycle
          refused_next = refused_next || !op_jtag_reg;
          jref_next = op_jtag_reg;
          state_next = S_IDLE;
        end
        else
        begin
          mem_en = 1'b1;
          state_next = op_pgm_reg ? S_PGW : S_RDW;
        end
      end
      S_RDW:
      begin
        if (op_jtag_reg)
        begin
          jrd_next = mem_rdata;
          jack_next = 1'b1;
        end
        else
          swrd_next = mem_rdata;
        state_next = S_IDLE;
      end
      S_PGW:
      begin
        // Fuses only go from 0 to 1
        mem_addr = op_sec_reg ? otpsec_pkg::OTP_SEC_ROW : otpsec_phys(op_row_reg, sec_reg, rep_reg);
        mem_en = 1'b1;
        mem_we = 1'b1;
        mem_wdata = mem_rdata | op_data_reg;
        jack_next = op_jtag_reg;
        state_next = S_IDLE;
      end
    endcase
    // A command written while one is taken is not lost
    if (ctrl_wr && i_wdata[otpsec_pkg::CTRL_PROGRAM])
      pend_pgm_next = 1'b1;
    if (ctrl_wr && i_wdata[otpsec_pkg::CTRL_READ])
      pend_rd_next = 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg <= S_LOAD;
      sec_reg <= otpsec_pkg::REG_ZERO;
      loaded_reg <= 1'b0;
      secure_reg <= 1'b0;
      run_reg <= 1'b0;
      idx_reg <= 12'h000;
      cpa_reg <= 12'h000;
      cpv_reg <= 1'b0;
      op_row_reg <= '0;
      op_data_reg <= otpsec_pkg::REG_ZERO;
      op_sec_reg <= 1'b0;
      op_jtag_reg <= 1'b0;
      op_pgm_reg <= 1'b0;
      pend_pgm_reg <= 1'b0;
      pend_rd_reg <= 1'b0;
      tgt_sec_reg <= 1'b0;
      refused_reg <= 1'b0;
      addr_reg <= 16'h0000;
      data_reg <= otpsec_pkg::REG_ZERO;
      rep_reg <= 16'h0000;
      swrd_reg <= otpsec_pkg::REG_ZERO;
      jack_reg <= 1'b0;
      jref_reg <= 1'b0;
      jrd_reg <= otpsec_pkg::REG_ZERO;
    end
    else
    begin
      state_reg <= state_next;
      sec_reg <= sec_next;
      loaded_reg <= loaded_next;
      secure_reg <= secure_next;
      run_reg <= run_next;
      idx_reg <= idx_next;
      cpa_reg <= cpa_next;
      cpv_reg <= cpv_next;
      op_row_reg <= op_row_next;
      op_data_reg <= op_data_next;
      op_sec_reg <= op_sec_next;
      op_jtag_reg <= op_jtag_next;
      op_pgm_reg <= op_pgm_next;
      pend_pgm_reg <= pend_pgm_next;
      pend_rd_reg <= pend_rd_next;
      tgt_sec_reg <= tgt_sec_next;
      refused_reg <= refused_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      rep_reg <= rep_next;
      swrd_reg <= swrd_next;
      jack_reg <= jack_next;
      jref_reg <= jref_next;
      jrd_reg <= jrd_next;
    end
  end

  assign o_core_run = run_reg;
  assign o_jtag_otp_ack = jack_reg;
  assign o_jtag_otp_refuse = jref_reg;
  assign o_jtag_otp_rdata = jrd_reg;

  // Pin gates and bus read; pin gates closed until the word is loaded, bus reads served from reset
  logic [31:0] rdata_next;
  logic [31:0] status;
  logic boot_otp_next, jgrant_next, lgrant_next, lref_next, dbg_oe_next, dbg_req_next;
  logic [1:0] boot_sel_next;
  logic sram_we_next;
  logic [otpsec_pkg::SRAM_AW-1:0] sram_addr_next;
  logic [31:0] sram_wdata_next;
  logic [otpsec_pkg::SEC_UID_W-1:0] uid_next;

  always_comb
  begin
    status = otpsec_pkg::REG_ZERO;
    status[otpsec_pkg::STAT_LOADED] = loaded_reg;
    status[otpsec_pkg::STAT_BUSY] = state_reg != S_IDLE;
    status[otpsec_pkg::STAT_REFUSED] = refused_reg;
    status[otpsec_pkg::STAT_RUNNING] = run_reg;
    rdata_next = otpsec_pkg::REG_ZERO;
    if (i_re)
    begin
      unique case (i_addr)
        otpsec_pkg::REG_SEC: rdata_next = sec_reg;
        otpsec_pkg::REG_ADDR: rdata_next = {16'h0000, addr_reg};
        otpsec_pkg::REG_DATA: rdata_next = data_reg;
        otpsec_pkg::REG_CTRL: rdata_next = {29'h0000_0000, tgt_sec_reg, pend_rd_reg, pend_pgm_reg};
        otpsec_pkg::REG_STATUS: rdata_next = status;
        otpsec_pkg::REG_RDATA: rdata_next = swrd_reg;
        otpsec_pkg::REG_REPAIR: rdata_next = {16'h0000, rep_reg};
        default: rdata_next = otpsec_pkg::REG_ZERO;
      endcase
    end
    boot_otp_next = secure_reg;
    boot_sel_next = i_boot_sel;
    jgrant_next = loaded_reg && !sec_reg[otpsec_pkg::SEC_JTAG_OFF] && i_jtag_req;
    lgrant_next = loaded_reg && !sec_reg[otpsec_pkg::SEC_LINK_OFF] && i_link_req;
    lref_next = i_link_req && !lgrant_next;
    dbg_oe_next = loaded_reg && !sec_reg[otpsec_pkg::SEC_DEBUG_OFF] && i_core_break;
    dbg_req_next = loaded_reg && !sec_reg[otpsec_pkg::SEC_DEBUG_OFF] && !i_debug_n_in;
    uid_next = sec_reg[otpsec_pkg::SEC_UID_MSB:otpsec_pkg::SEC_UID_LSB];
    sram_we_next = cpv_reg;
    sram_addr_next = {{(otpsec_pkg::SRAM_AW - 12){1'b0}}, cpa_reg};
    sram_wdata_next = mem_rdata;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= otpsec_pkg::REG_ZERO;
      o_boot_from_otp <= 1'b0;
      o_boot_sel <= 2'h0;
      o_jtag_grant <= 1'b0;
      o_link_grant <= 1'b0;
      o_link_refuse <= 1'b0;
      o_debug_n_out <= 1'b0;
      o_debug_n_oe <= 1'b0;
      o_debug_req <= 1'b0;
      o_jtag_user_code_extension <= '0;
      o_sram_we <= 1'b0;
      o_sram_addr <= '0;
      o_sram_wdata <= otpsec_pkg::REG_ZERO;
    end
    else
    begin
      o_rdata <= rdata_next;
      o_boot_from_otp <= boot_otp_next;
      o_boot_sel <= boot_sel_next;
      o_jtag_grant <= jgrant_next;
      o_link_grant <= lgrant_next;
      o_link_refuse <= lref_next;
      o_debug_n_out <= 1'b0;
      o_debug_n_oe <= dbg_oe_next;
      o_debug_req <= dbg_req_next;
      o_jtag_user_code_extension <= uid_next;
      o_sram_we <= sram_we_next;
      o_sram_addr <= sram_addr_next;
      o_sram_wdata <= sram_wdata_next;
    end
  end
endmodule : otpsec_ctrl
`default_nettype wire

//--- otpsec_ctrl_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module otpsec_ctrl_chk (
  input wire logic i_clk, // Clock
  input wire logic i_rst_n, // Reset
  input wire logic [7:0] i_addr, // Seen
  input wire logic [31:0] i_wdata, // Seen
  input wire logic i_we, // Seen
  input wire logic i_re, // Seen
  input wire logic [31:0] o_rdata, // Seen
  input wire logic [1:0] i_boot_sel, // Seen
  input wire logic o_boot_from_otp, // Seen
  input wire logic [1:0] o_boot_sel, // Seen
  input wire logic o_core_run, // Seen
  input wire logic o_sram_we, // Seen
  input wire logic [otpsec_pkg::SRAM_AW-1:0] o_sram_addr, // Seen
  input wire logic [31:0] o_sram_wdata, // Seen
  input wire logic i_jtag_req, // Seen
  input wire logic o_jtag_grant, // Seen
  input wire logic i_link_req, // Seen
  input wire logic o_link_grant, // Seen
  input wire logic o_link_refuse, // Seen
  input wire logic i_jtag_otp_rd, // Seen
  input wire logic i_jtag_otp_wr, // Seen
  input wire logic i_jtag_otp_sec, // Seen
  input wire logic [15:0] i_jtag_otp_addr, // Seen
  input wire logic [31:0] i_jtag_otp_wdata, // Seen
  input wire logic o_jtag_otp_ack, // Seen
  input wire logic o_jtag_otp_refuse, // Seen
  input wire logic [31:0] o_jtag_otp_rdata, // Seen
  input wire logic i_core_break, // Seen
  input wire logic i_debug_n_in, // Seen
  input wire logic o_debug_n_out, // Seen
  input wire logic o_debug_n_oe, // Seen
  input wire logic o_debug_req, // Seen
  input wire logic [otpsec_pkg::SEC_UID_W-1:0] o_jtag_user_code_extension // Seen
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_rdata_slot: assert property (o_rdata != 32'h0000_0000 |-> $past(i_re))
    else $error("read data outside its slot");
  a_run_after_load: assert property ($rose(i_rst_n) |-> !o_core_run [*3])
    else $error("processor released before load");
  a_copy_before_run: assert property (o_sram_we |-> !o_core_run)
    else $error("copy while processor runs");
  a_copy_addr_step: assert property (o_sram_we && $past(o_sram_we) |->
    o_sram_addr == $past(o_sram_addr) + 14'h1)
    else $error("copy address skipped");
  a_jtag_grant_cause: assert property (o_jtag_grant |-> $past(i_jtag_req))
    else $error("grant without request");
  a_link_excl: assert property (!(o_link_grant && o_link_refuse))
    else $error("link granted and refused");
  a_link_refuse_cause: assert property (o_link_refuse |-> $past(i_link_req))
    else $error("refuse without request");
  a_otp_pulse_cause: assert property (o_jtag_otp_ack |->
    !o_jtag_otp_refuse && $past(i_jtag_otp_rd || i_jtag_otp_wr))
    else $error("bad otp answer");
  a_otp_pulse_one: assert property (o_jtag_otp_refuse |=> !o_jtag_otp_refuse)
    else $error("refuse pulse too long");
  a_debug_drive_low: assert property (o_debug_n_oe |-> !o_debug_n_out && $past(i_core_break))
    else $error("debug pin misdriven");
  a_uid_stable: assert property (o_core_run && $past(o_core_run) |-> $stable(o_jtag_user_code_extension))
    else $error("user code moved");
  c_secure_run: cover property (o_boot_from_otp && o_core_run);
  c_otp_refuse: cover property (o_jtag_otp_refuse);
  c_link_refuse: cover property (o_link_refuse);
  c_copy: cover property (o_sram_we);
endmodule : otpsec_ctrl_chk
bind otpsec_ctrl otpsec_ctrl_chk u_chk (.*);
`default_nettype wire

//--- otpsec_jtag_model.sv
`timescale 1ns/1ns
`default_nettype none
module otpsec_jtag_model (
  input wire logic i_clk, // Clock
  input wire logic i_ack, // Done pulse
  input wire logic i_refuse, // Refused pulse
  output logic o_rd, // Read request
  output logic o_wr, // Program request
  output logic o_sec, // Security row target
  output logic [15:0] o_addr, // Row
  output logic [31:0] o_wdata // Program data
);
  initial
  begin
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_sec = 1'b0;
    o_addr = 16'hffff;
    o_wdata = 32'hffff_ffff;
  end
  // Request held until answered or for at most 40 cycles; res 1 ack, 2 refuse, 0 none
  task op(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [1:0] res);
    int n;
    res = 2'h0;
    @(posedge i_clk);
    o_rd <= !w;
    o_wr <= w;
    o_addr <= a;
    o_wdata <= d;
    for (n = 0; n < 40 && res == 2'h0; n++)
    begin
      @(posedge i_clk);
      if (i_ack)
        res = 2'h1;
      else if (i_refuse)
        res = 2'h2;
    end
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    // Released lines must not look still valid
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask : op
endmodule : otpsec_jtag_model
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic i_clk, i_rst_n, i_we, i_re, i_jtag_req, i_link_req, i_core_break, i_debug_n_in;
  logic i_jtag_otp_rd, i_jtag_otp_wr, i_jtag_otp_sec, o_boot_from_otp, o_core_run, o_sram_we;
  logic o_jtag_grant, o_link_grant, o_link_refuse, o_jtag_otp_ack, o_jtag_otp_refuse;
  logic o_debug_n_out, o_debug_n_oe, o_debug_req;
  logic [7:0] i_addr;
  logic [15:0] i_jtag_otp_addr;
  logic [1:0] i_boot_sel, o_boot_sel, res;
  logic [31:0] i_wdata, o_rdata, o_sram_wdata, i_jtag_otp_wdata, o_jtag_otp_rdata, v, sram0;
  logic [otpsec_pkg::SRAM_AW-1:0] o_sram_addr;
  logic [otpsec_pkg::SEC_UID_W-1:0] o_jtag_user_code_extension;
  int fail_count, comparisons, copies;
  localparam logic [31:0] SEC_A = 32'ha96a_e123;
  otpsec_ctrl #(.COPY_ROWS(4)) dut (.*);
  otpsec_jtag_model u_jtag (.i_clk(i_clk), .i_ack(o_jtag_otp_ack), .i_refuse(o_jtag_otp_refuse),
    .o_rd(i_jtag_otp_rd), .o_wr(i_jtag_otp_wr), .o_sec(i_jtag_otp_sec), .o_addr(i_jtag_otp_addr),
    .o_wdata(i_jtag_otp_wdata));
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
    if (!i_rst_n)
      copies <= 0;
    else if (o_sram_we)
    begin
      if (o_sram_addr == 14'h0000)
        sram0 <= o_sram_wdata;
      copies <= copies + 1;
    end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_we <= 1'b1;
    @(posedge i_clk);
    i_we <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_re <= 1'b1;
    @(posedge i_clk);
    i_re <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd
  task otp(input logic [15:0] a, input logic [31:0] d, input logic [31:0] c);
    int n;
    wr(otpsec_pkg::REG_ADDR, {16'h0000, a});
    wr(otpsec_pkg::REG_DATA, d);
    wr(otpsec_pkg::REG_CTRL, c);
    repeat (3) @(posedge i_clk);
    v = 32'h0000_0002;
    for (n = 0; n < 40 && v[1] !== 1'b0; n++)
      rd(otpsec_pkg::REG_STATUS, v);
    chk("busy", 0, v[1]);
  endtask : otp
  task otp_rd(input logic [15:0] a);
    otp(a, 32'h0000_0000, 32'h0000_0002);
    rd(otpsec_pkg::REG_RDATA, v);
  endtask : otp_rd
  // Power-up reset; the array keeps its contents across it
  task boot;
    int n;
    i_rst_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (n = 0; n < 100 && o_core_run !== 1'b1; n++)
      @(posedge i_clk);
    chk("core_run", 1, o_core_run);
  endtask : boot
  task gates(input logic open);
    @(posedge i_clk);
    i_jtag_req <= 1'b1;
    i_link_req <= 1'b1;
    i_core_break <= 1'b1;
    i_debug_n_in <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    chk("jtag_grant", open, o_jtag_grant);
    chk("link_grant", open, o_link_grant);
    chk("link_refuse", !open, o_link_refuse);
    chk("debug_oe", open, o_debug_n_oe);
    chk("debug_out", 0, o_debug_n_out);
    chk("debug_req", open, o_debug_req);
    @(posedge i_clk);
    i_jtag_req <= 1'b0;
    i_link_req <= 1'b0;
    i_core_break <= 1'b0;
    i_debug_n_in <= 1'b1;
  endtask : gates
  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    wrap_up;
  end
  initial
  begin
    i_rst_n = 1'b0;
    i_we = 1'b0;
    i_re = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    i_jtag_req = 1'b0;
    i_link_req = 1'b0;
    i_core_break = 1'b0;
    i_debug_n_in = 1'b1;
    i_boot_sel = 2'h2;
    boot;
    rd(otpsec_pkg::REG_SEC, v);
    chk("sec_blank", 0, v);
    chk("uid_blank", 0, o_jtag_user_code_extension);
    chk("boot_otp", 0, o_boot_from_otp);
    chk("boot_sel", 2, o_boot_sel);
    rd(8'h40, v);
    chk("unmapped", 0, v);
    gates(1'b1);
    otp(16'h0000, 32'h1234_5678, 32'h0000_0001);
    otp(16'h0600, 32'h0000_00a5, 32'h0000_0001);
    otp_rd(16'h0000);
    chk("row0", 32'h1234_5678, v);
    u_jtag.op(1'b0, 16'h0600, 32'h0000_0000, res);
    chk("jtag_ack", 1, res);
    chk("jtag_rdata", 32'h0000_00a5, o_jtag_otp_rdata);
    otp(16'h0000, SEC_A, 32'h0000_0005);
    boot;
    rd(otpsec_pkg::REG_SEC, v);
    chk("sec_word", SEC_A, v);
    chk("uid", 10'h2a5, o_jtag_user_code_extension);
    chk("boot_otp", 1, o_boot_from_otp);
    chk("copies", 4, copies);
    chk("sram0", 32'h1234_5678, sram0);
    gates(1'b0);
    u_jtag.op(1'b0, 16'h0600, 32'h0000_0000, res);
    chk("jtag_refuse", 2, res);
    otp(16'h0000, 32'hffff_0000, 32'h0000_0001);
    rd(otpsec_pkg::REG_STATUS, v);
    chk("lock0", 1, v[2]);
    wr(otpsec_pkg::REG_STATUS, 32'h0000_0004);
    otp_rd(16'h0000);
    chk("row0_kept", 32'h1234_5678, v);
    otp(16'h0200, 32'h0000_000f, 32'h0000_0001);
    otp_rd(16'h0200);
    chk("row512", 32'h0000_000f, v);
    // Master lock plus redundancy enable
    otp(16'h0000, 32'h0000_1080, 32'h0000_0005);
    boot;
    rd(otpsec_pkg::REG_SEC, v);
    chk("sec_master", SEC_A | 32'h0000_1080, v);
    otp(16'h0200, 32'h0000_00f0, 32'h0000_0001);
    otp_rd(16'h0200);
    chk("row512_kept", 32'h0000_000f, v);
    // Row 512 remapped to blank spare 1
    wr(otpsec_pkg::REG_REPAIR, 32'h0000_9200);
    otp_rd(16'h0200);
    chk("spare_row", 0, v);
    wr(otpsec_pkg::REG_STATUS, 32'h0000_0004);
    otp(16'h0000, 32'h0000_0080, 32'h0000_0005);
    rd(otpsec_pkg::REG_STATUS, v);
    chk("sec_locked", 1, v[2]);
    wrap_up;
  end
endmodule : tb
`default_nettype wire
